// ===== upstream_bus_map.svh
// Contract
// R1: parity makes ad, cbe, parity ones even
// R2: address parity driven the clock after address
// R3: write parity valid one clock after ready
// R4: read parity comes from target next clock
// R5: parity released one cycle after ad
// R6: parked bus drives valid levels on grant
// R7: word moves when both readies sampled low
// R8: data valid with ready, address at frame
// R9: command in address phase, enables after
// R10: frame held, dropped for final phase
// R11: strobes driven high one cycle before release
// R12: asserted ready held until phase completes
// R13: no claim within five cycles aborts
// R14: claim accepts, stop ends the transaction
// R15: lock asserted one clock after address
// R16: config select is the type 0 chip select
// R17: request stays high two clocks before again
// R18: bus released while reset is low
`ifndef UPSTREAM_BUS_MAP_SVH
`define UPSTREAM_BUS_MAP_SVH
`define CLK_PERIOD_NS 10
`define CLAIM_WAIT_CYCLES 5
`define REQ_IDLE_CYCLES 2
`define CMD_CFG_READ 4'hA
`define CMD_CFG_WRITE 4'hB
`endif

// ===== upstream_bus_pkg.sv
package upstream_bus_pkg;
  typedef enum logic [3:0] {
    ST_IDLE, ST_REQ, ST_ADDR, ST_DATA, ST_LAST_HI, ST_TURN, ST_GAP
  } master_state_t;
endpackage : upstream_bus_pkg

// ===== skid_buffer.sv
`timescale 1ns/1ps
module skid_buffer (
  input wire logic clk_i, // clock
  input wire logic resetn_i, // sync reset, low active
  input wire logic ce_i, // clock enable
  input wire logic in_valid_i, // word offered
  output logic in_ready_o, // room for a word
  input wire logic [31:0] in_data_i, // word in
  output logic out_valid_o, // word available
  input wire logic out_ready_i, // consumer takes
  output logic [31:0] out_data_o // word out
);
  logic [31:0] mem_r [0:1];
  logic [31:0] mem_nxt [0:1];
  logic wp_r, wp_nxt, rp_r, rp_nxt;
  logic [1:0] cnt_r, cnt_nxt;
  logic push, pop;
  always_comb
  begin
    push = in_valid_i && (cnt_r != 2'h2);
    pop = out_ready_i && (cnt_r != 2'h0);
    mem_nxt[0] = mem_r[0];
    mem_nxt[1] = mem_r[1];
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (push)
    begin
      mem_nxt[wp_r] = in_data_i;
      wp_nxt = ~wp_r;
    end
    if (pop)
      rp_nxt = ~rp_r;
    if (push && !pop)
      cnt_nxt = cnt_r + 2'h1;
    else if (pop && !push)
      cnt_nxt = cnt_r - 2'h1;
  end
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      mem_r[0] <= 32'h0;
      mem_r[1] <= 32'h0;
      wp_r <= 1'b0;
      rp_r <= 1'b0;
      cnt_r <= 2'h0;
    end
    else if (ce_i)
    begin
      mem_r[0] <= mem_nxt[0];
      mem_r[1] <= mem_nxt[1];
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  assign in_ready_o = (cnt_r != 2'h2);
  assign out_valid_o = (cnt_r != 2'h0);
  assign out_data_o = mem_r[rp_r];
endmodule : skid_buffer

// ===== upstream_bus_master.sv
`timescale 1ns/1ps
`include "upstream_bus_map.svh"
module upstream_bus_master (
  input wire logic clk_i, // bus clock
  input wire logic resetn_i, // sync reset, low active
  input wire logic ce_i, // clock enable
  input wire logic cmd_valid_i, // start one access
  output logic cmd_ready_o, // access accepted
  input wire logic [3:0] cmd_code_i, // bus command
  input wire logic [31:0] cmd_addr_i, // address
  input wire logic [3:0] cmd_be_i, // byte enables, all data phases
  input wire logic [3:0] cmd_len_i, // data phases minus one
  input wire logic cmd_lock_i, // run locked
  input wire logic cmd_cfg_sel_i, // raise config select, config read or write commands only
  input wire logic wr_valid_i, // write word offered
  output logic wr_ready_o, // write word taken
  input wire logic [31:0] wr_data_i, // write word
  output logic rd_valid_o, // read word out
  input wire logic rd_ready_i, // read consumer ready
  output logic [31:0] rd_data_o, // read word
  output logic done_o, // access ended, pulse
  output logic [1:0] status_o, // 0 ok, 1 abort, 2 stop
  output logic req_n_o, // bus request
  input wire logic gnt_n_i, // bus grant
  input wire logic [31:0] ad_i, // ad lines in
  output logic [31:0] ad_o, // ad lines out
  output logic ad_oe_n_o, // ad enable, low drives
  input wire logic [3:0] upstream_cmd_byte_en_i, // cbe in
  output logic [3:0] upstream_cmd_byte_en_o, // cbe out
  output logic cbe_oe_n_o, // cbe enable, low drives
  input wire logic upstream_parity_i, // parity in
  output logic upstream_parity_o, // parity out
  output logic par_oe_n_o, // parity enable, low drives
  input wire logic frame_n_i, // frame in
  output logic frame_n_o, // frame out
  output logic frame_oe_n_o, // frame enable, low drives
  output logic upstream_initiator_ready_n_o, // irdy out
  output logic irdy_oe_n_o, // irdy enable, low drives
  input wire logic upstream_target_ready_n_i, // trdy in
  input wire logic upstream_claim_n_i, // devsel in
  input wire logic stop_n_i, // stop in
  output logic lock_n_o, // lock out
  output logic lock_oe_n_o, // lock enable, low drives
  output logic upstream_config_select_o, // idsel to device
  output logic par_err_o // read parity mismatch, pulse
);
  upstream_bus_pkg::master_state_t st_r, st_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [2:0] wait_r, wait_nxt;
  logic [1:0] gap_r, gap_nxt;
  logic [31:0] ad_r, ad_nxt;
  logic [3:0] cbe_r, cbe_nxt;
  logic par_r, par_nxt, ad_oe_r, ad_oe_nxt, par_oe_r, par_oe_nxt;
  logic frame_r, frame_nxt, frame_oe_r, frame_oe_nxt;
  logic irdy_r, irdy_nxt, irdy_oe_r, irdy_oe_nxt;
  logic lock_r, lock_nxt, lock_oe_r, lock_oe_nxt;
  logic req_r, req_nxt, cmd_rdy_r, cmd_rdy_nxt, done_r, done_nxt;
  logic [1:0] stat_r, stat_nxt;
  logic idsel_r, idsel_nxt, write_r, write_nxt, claimed_r, claimed_nxt;
  logic [3:0] cmd_r, cmd_nxt, be_r, be_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic lockreq_r, lockreq_nxt;
  logic chk_r, chk_nxt, perr_r, perr_nxt;
  logic [31:0] rdw_r;
  logic rdv_r, rdw_nxt_v;
  logic [31:0] rdw_nxt;
  logic rb_in_ready;
  logic xfer, last, wr_take, cbe_oe_r, cbe_oe_nxt;
  skid_buffer u_rd_buf (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .in_valid_i(rdv_r),
    .in_ready_o(rb_in_ready),
    .in_data_i(rdw_r),
    .out_valid_o(rd_valid_o),
    .out_ready_i(rd_ready_i),
    .out_data_o(rd_data_o)
  );
  // word moves only when both readies low [R7]
  assign xfer = !irdy_r && !upstream_target_ready_n_i && (st_r == upstream_bus_pkg::ST_DATA);
  assign last = (cnt_r == 4'h0);
  always_comb
  begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    wait_nxt = wait_r;
    gap_nxt = gap_r;
    ad_nxt = ad_r;
    cbe_nxt = cbe_r;
    // parity of what was on the lines last cycle [R1] [R2] [R3]
    par_nxt = ^{ad_r, cbe_r};
    ad_oe_nxt = ad_oe_r;
    par_oe_nxt = ad_oe_r; // [R5]
    frame_nxt = frame_r;
    frame_oe_nxt = frame_oe_r;
    irdy_nxt = irdy_r;
    irdy_oe_nxt = irdy_oe_r;
    lock_nxt = lock_r;
    lock_oe_nxt = lock_oe_r;
    req_nxt = req_r;
    cmd_rdy_nxt = 1'b0;
    done_nxt = 1'b0;
    stat_nxt = stat_r;
    idsel_nxt = idsel_r;
    write_nxt = write_r;
    claimed_nxt = claimed_r;
    cmd_nxt = cmd_r;
    be_nxt = be_r;
    addr_nxt = addr_r;
    lockreq_nxt = lockreq_r;
    wr_take = 1'b0;
    cbe_oe_nxt = cbe_oe_r;
    rdw_nxt = rdw_r;
    rdw_nxt_v = 1'b0;
    // read parity arrives the clock after the word [R4]
    chk_nxt = xfer && !write_r;
    perr_nxt = chk_r && (upstream_parity_i != ^{ad_r, cbe_r});
    // released lines are captured so that read parity can be checked
    if (!write_r && ad_oe_r)
      ad_nxt = ad_i;
    case (st_r)
      upstream_bus_pkg::ST_IDLE:
      begin
        // park on grant with valid levels [R6]
        ad_oe_nxt = gnt_n_i;
        cbe_oe_nxt = gnt_n_i;
        if (!gnt_n_i)
        begin
          ad_nxt = 32'h0;
          cbe_nxt = 4'h0;
        end
        if (cmd_valid_i && rb_in_ready)
        begin
          cmd_rdy_nxt = 1'b1;
          cmd_nxt = cmd_code_i;
          addr_nxt = cmd_addr_i;
          be_nxt = cmd_be_i;
          cnt_nxt = cmd_len_i;
          lockreq_nxt = cmd_lock_i;
          write_nxt = cmd_code_i[0];
          // type 0 config select [R16]
          idsel_nxt = cmd_cfg_sel_i &&
            (cmd_code_i == `CMD_CFG_READ || cmd_code_i == `CMD_CFG_WRITE);
          req_nxt = 1'b0;
          st_nxt = upstream_bus_pkg::ST_REQ;
        end
      end
      upstream_bus_pkg::ST_REQ:
      begin
        if (!gnt_n_i && frame_n_i && upstream_target_ready_n_i)
        begin
          // address and command in the frame cycle [R8] [R9]
          ad_nxt = addr_r;
          cbe_nxt = cmd_r;
          ad_oe_nxt = 1'b0;
          cbe_oe_nxt = 1'b0;
          frame_nxt = 1'b0; // [R10]
          frame_oe_nxt = 1'b0;
          req_nxt = 1'b1;
          wait_nxt = 3'h0;
          claimed_nxt = 1'b0;
          st_nxt = upstream_bus_pkg::ST_ADDR;
        end
      end
      upstream_bus_pkg::ST_ADDR:
      begin
        cbe_nxt = be_r; // [R9]
        irdy_oe_nxt = 1'b0;
        if (lockreq_r)
        begin
          lock_nxt = 1'b0; // [R15]
          lock_oe_nxt = 1'b0;
        end
        if (write_r)
        begin
          if (wr_valid_i)
          begin
            ad_nxt = wr_data_i;
            irdy_nxt = 1'b0;
            wr_take = 1'b1;
          end
        end
        else
        begin
          ad_oe_nxt = 1'b1;
          irdy_nxt = 1'b0;
        end
        if (last && (!write_r || wr_valid_i))
          frame_nxt = 1'b1; // [R10]
        st_nxt = upstream_bus_pkg::ST_DATA;
      end
      upstream_bus_pkg::ST_DATA:
      begin
        if (!upstream_claim_n_i)
          claimed_nxt = 1'b1; // [R14]
        wait_nxt = wait_r + 3'h1;
        if (xfer)
        begin
          if (!write_r)
          begin
            rdw_nxt = ad_i;
            rdw_nxt_v = 1'b1;
          end
          if (last || !stop_n_i)
          begin
            stat_nxt = stop_n_i ? 2'h0 : 2'h2;
            st_nxt = upstream_bus_pkg::ST_LAST_HI;
          end
          else
          begin
            cnt_nxt = cnt_r - 4'h1;
            // on a normal transfer, frame only drops together with a ready initiator; a stop or abort drops it regardless
            if (cnt_r == 4'h1 && (!write_r || wr_valid_i))
              frame_nxt = 1'b1; // [R10]
            if (write_r)
            begin
              irdy_nxt = !wr_valid_i;
              ad_nxt = wr_data_i;
              wr_take = wr_valid_i;
            end
          end
        end
        else if (!upstream_claim_n_i || claimed_r)
        begin
          // held once asserted until the phase ends [R12]
          if (irdy_r && write_r && wr_valid_i)
          begin
            irdy_nxt = 1'b0;
            ad_nxt = wr_data_i;
            wr_take = 1'b1;
            if (last)
              frame_nxt = 1'b1; // [R10]
          end
          if (!stop_n_i)
          begin
            frame_nxt = 1'b1;
            if (!irdy_r)
            begin
              stat_nxt = 2'h2;
              st_nxt = upstream_bus_pkg::ST_LAST_HI;
            end
          end
        end
        else if (wait_r == 3'(`CLAIM_WAIT_CYCLES - 1))
        begin
          stat_nxt = 2'h1; // [R13]
          st_nxt = upstream_bus_pkg::ST_LAST_HI;
        end
        if (st_nxt == upstream_bus_pkg::ST_LAST_HI)
        begin
          frame_nxt = 1'b1; // [R11]
          irdy_nxt = 1'b1;
        end
      end
      upstream_bus_pkg::ST_LAST_HI:
      begin
        frame_oe_nxt = 1'b1; // [R11]
        irdy_oe_nxt = 1'b1;
        ad_oe_nxt = 1'b1;
        cbe_oe_nxt = 1'b1;
        if (lockreq_r)
          lock_nxt = 1'b1;
        st_nxt = upstream_bus_pkg::ST_TURN;
      end
      upstream_bus_pkg::ST_TURN:
      begin
        lock_oe_nxt = 1'b1;
        idsel_nxt = 1'b0;
        done_nxt = 1'b1;
        gap_nxt = 2'h0;
        st_nxt = upstream_bus_pkg::ST_GAP;
      end
      upstream_bus_pkg::ST_GAP:
      begin
        gap_nxt = gap_r + 2'h1;
        if (gap_r == 2'(`REQ_IDLE_CYCLES - 2))
          st_nxt = upstream_bus_pkg::ST_IDLE; // [R17]
      end
      default:
        st_nxt = upstream_bus_pkg::ST_IDLE;
    endcase
  end
  always_ff @(posedge clk_i)
  begin
    if (!resetn_i)
    begin
      // bus lines released while reset holds [R18]
      st_r <= upstream_bus_pkg::ST_IDLE;
      cnt_r <= 4'h0;
      wait_r <= 3'h0;
      gap_r <= 2'h0;
      ad_r <= 32'h0;
      cbe_r <= 4'h0;
      par_r <= 1'b0;
      ad_oe_r <= 1'b1;
      cbe_oe_r <= 1'b1;
      par_oe_r <= 1'b1;
      frame_r <= 1'b1;
      frame_oe_r <= 1'b1;
      irdy_r <= 1'b1;
      irdy_oe_r <= 1'b1;
      lock_r <= 1'b1;
      lock_oe_r <= 1'b1;
      req_r <= 1'b1;
      cmd_rdy_r <= 1'b0;
      done_r <= 1'b0;
      stat_r <= 2'h0;
      idsel_r <= 1'b0;
      write_r <= 1'b0;
      claimed_r <= 1'b0;
      cmd_r <= 4'h0;
      be_r <= 4'h0;
      addr_r <= 32'h0;
      lockreq_r <= 1'b0;
      chk_r <= 1'b0;
      perr_r <= 1'b0;
      rdw_r <= 32'h0;
      rdv_r <= 1'b0;
    end
    else if (ce_i)
    begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      wait_r <= wait_nxt;
      gap_r <= gap_nxt;
      ad_r <= ad_nxt;
      cbe_r <= cbe_nxt;
      par_r <= par_nxt;
      ad_oe_r <= ad_oe_nxt;
      cbe_oe_r <= cbe_oe_nxt;
      par_oe_r <= par_oe_nxt;
      frame_r <= frame_nxt;
      frame_oe_r <= frame_oe_nxt;
      irdy_r <= irdy_nxt;
      irdy_oe_r <= irdy_oe_nxt;
      lock_r <= lock_nxt;
      lock_oe_r <= lock_oe_nxt;
      req_r <= req_nxt;
      cmd_rdy_r <= cmd_rdy_nxt;
      done_r <= done_nxt;
      stat_r <= stat_nxt;
      idsel_r <= idsel_nxt;
      write_r <= write_nxt;
      claimed_r <= claimed_nxt;
      cmd_r <= cmd_nxt;
      be_r <= be_nxt;
      addr_r <= addr_nxt;
      lockreq_r <= lockreq_nxt;
      chk_r <= chk_nxt;
      perr_r <= perr_nxt;
      rdw_r <= rdw_nxt;
      rdv_r <= rdw_nxt_v;
    end
  end
  assign cmd_ready_o = cmd_rdy_r;
  assign wr_ready_o = wr_take;
  assign done_o = done_r;
  assign status_o = stat_r;
  assign req_n_o = req_r;
  assign ad_o = ad_r;
  assign ad_oe_n_o = ad_oe_r;
  assign upstream_cmd_byte_en_o = cbe_r;
  assign cbe_oe_n_o = cbe_oe_r;
  assign upstream_parity_o = par_r;
  assign par_oe_n_o = par_oe_r;
  assign frame_n_o = frame_r;
  assign frame_oe_n_o = frame_oe_r;
  assign upstream_initiator_ready_n_o = irdy_r;
  assign irdy_oe_n_o = irdy_oe_r;
  assign lock_n_o = lock_r;
  assign lock_oe_n_o = lock_oe_r;
  assign upstream_config_select_o = idsel_r;
  assign par_err_o = perr_r;
  // checks pause with the clock enable; a frozen cycle breaks the one-cycle offsets
  sequence s_ad_release;
    $rose(ad_oe_r);
  endsequence
  sequence s_data_wait;
    (st_r == upstream_bus_pkg::ST_DATA) && !irdy_r && upstream_target_ready_n_i && stop_n_i &&
      (claimed_r || !upstream_claim_n_i);
  endsequence
  a_parity_even: assert property (@(posedge clk_i) disable iff (!resetn_i || !ce_i) // [R1]
    !par_oe_r && $past(ce_i) |-> par_r == ^{$past(ad_r), $past(cbe_r)})
    else $error("parity does not match the previous cycle");
  a_par_release: assert property (@(posedge clk_i) disable iff (!resetn_i || !ce_i) // [R5]
    s_ad_release |-> !par_oe_r ##1 par_oe_r)
    else $error("parity not released one cycle after ad");
  a_frame_release: assert property (@(posedge clk_i) disable iff (!resetn_i || !ce_i) // [R11]
    $rose(frame_oe_r) |-> $past(frame_r) && !$past(frame_oe_r))
    else $error("frame released without a high cycle");
  a_irdy_release: assert property (@(posedge clk_i) disable iff (!resetn_i || !ce_i) // [R11]
    $rose(irdy_oe_r) |-> $past(irdy_r) && !$past(irdy_oe_r))
    else $error("initiator ready released without a high cycle");
  a_irdy_held: assert property (@(posedge clk_i) disable iff (!resetn_i || !ce_i) // [R12]
    s_data_wait |=> !irdy_r)
    else $error("initiator ready dropped inside a data phase");
  a_claim_timeout: assert property (@(posedge clk_i) disable iff (!resetn_i || !ce_i) // [R13]
    (st_r == upstream_bus_pkg::ST_DATA) && (wait_r == 3'(`CLAIM_WAIT_CYCLES - 1)) &&
      upstream_claim_n_i && !claimed_r |=> (st_r == upstream_bus_pkg::ST_LAST_HI) &&
      (stat_r == 2'h1))
    else $error("unclaimed access not aborted");
  a_cmd_phase: assert property (@(posedge clk_i) disable iff (!resetn_i || !ce_i) // [R9]
    (st_r == upstream_bus_pkg::ST_ADDR) |-> (cbe_r == cmd_r) && !frame_r && !cbe_oe_r)
    else $error("command not on the lines in the address phase");
  a_req_gap: assert property (@(posedge clk_i) disable iff (!resetn_i || !ce_i) // [R17]
    $rose(req_r) |=> req_r)
    else $error("request raised again too soon");
endmodule : upstream_bus_master

// ===== bus_target.sv
`timescale 1ns/1ps
module bus_target (
  input wire logic clk_i, // bus clock
  input wire logic [1:0] mode_i, // 0 fast, 1 slow, 2 silent, 3 stop
  input wire logic frame_n_i, // frame on bus
  input wire logic irdy_n_i, // initiator ready on bus
  input wire logic [31:0] ad_i, // ad on bus
  input wire logic [3:0] cbe_i, // cbe on bus
  output logic trdy_n_o, // target ready
  output logic claim_n_o, // device select
  output logic stop_n_o, // stop
  output logic ad_drv_o, // target drives ad
  output logic [31:0] ad_o, // read word
  output logic par_drv_o, // target drives parity
  output logic par_o // read parity
);
  logic busy = 0, rd = 0, fr_q = 1;
  logic [2:0] wait_c = 0;
  initial {trdy_n_o, claim_n_o, stop_n_o, ad_drv_o, par_drv_o, par_o, ad_o} = {4'hE, 34'h0};
  always @(posedge clk_i)
  begin
    fr_q <= frame_n_i;
    par_o <= ^{ad_i, cbe_i};
    par_drv_o <= ad_drv_o;
    if (!busy && fr_q && !frame_n_i)
    begin
      busy <= 1'b1;
      rd <= ~cbe_i[0];
      ad_o <= ad_i;
      wait_c <= (mode_i == 2'h1) ? 3'h3 : 3'h1;
    end
    else if (busy && frame_n_i && irdy_n_i)
    begin
      busy <= 1'b0;
      {trdy_n_o, claim_n_o, stop_n_o, ad_drv_o} <= 4'hE;
    end
    else if (busy && wait_c != 3'h0)
    begin
      wait_c <= wait_c - 3'h1;
      if (wait_c == 3'h1 && mode_i != 2'h2)
      begin
        claim_n_o <= 1'b0;
        trdy_n_o <= (mode_i == 2'h3);
        stop_n_o <= (mode_i != 2'h3);
        ad_drv_o <= rd;
      end
    end
    else if (busy && !irdy_n_i && !trdy_n_o)
    begin
      // next read word is only presented once the current one has moved
      ad_o <= ad_o + 32'h1;
      trdy_n_o <= (mode_i == 2'h1) || frame_n_i;
      if (frame_n_i)
        {claim_n_o, ad_drv_o} <= 2'h2;
    end
    else if (busy && !claim_n_o && stop_n_o)
      trdy_n_o <= 1'b0;
  end
endmodule : bus_target

// ===== tb_top.sv
`timescale 1ns/1ps
`include "upstream_bus_map.svh"
module tb_top;
  logic clk_i = 0, resetn_i = 0, ce_i = 1, cmd_valid_i = 0, cmd_lock_i = 0, cmd_cfg_sel_i = 0;
  logic [3:0] cmd_code_i = 4'h6, cmd_be_i = 4'hF, cmd_len_i = 4'h0;
  logic [31:0] cmd_addr_i = 32'h0, wr_data_i = 32'h0, ad_h = 32'h0, ad_q = 32'h0, rd_data_o, ad_o;
  logic wr_valid_i = 0, rd_ready_i = 1, gnt_n_i = 1, fr_q = 1, req_q = 1, par_h = 0, adr_q = 0;
  logic cmd_ready_o, wr_ready_o, rd_valid_o, done_o, req_n_o, ad_oe_n_o, cbe_oe_n_o, par_oe_n_o;
  logic frame_n_o, frame_oe_n_o, upstream_initiator_ready_n_o, irdy_oe_n_o, lock_n_o, lock_oe_n_o;
  logic upstream_parity_o, upstream_config_select_o, par_err_o, t_trdy, t_claim, t_stop;
  logic t_ad_drv, t_par_drv, t_par;
  logic [31:0] t_ad, ad_b, rd_q[$], wr_q[$], st_q[$];
  logic [3:0] upstream_cmd_byte_en_o, cbe_b, cbe_h = 4'h0, cbe_q = 4'h0;
  logic [3:0] codes[4] = '{4'h6, 4'h7, `CMD_CFG_READ, `CMD_CFG_WRITE};
  logic [1:0] status_o, mode = 2'h0;
  int errors = 0, checked = 0, dones = 0, hi = 0, seed = 32'hE4817D7E;
  // released lines show a changing pattern; strobes have pull-ups
  assign ad_b = !ad_oe_n_o ? ad_o : t_ad_drv ? t_ad : ad_h;
  assign cbe_b = !cbe_oe_n_o ? upstream_cmd_byte_en_o : cbe_h;
  wire par_b = !par_oe_n_o ? upstream_parity_o : t_par_drv ? t_par : par_h;
  wire frame_b = frame_oe_n_o | frame_n_o;
  wire irdy_b = irdy_oe_n_o | upstream_initiator_ready_n_o;
  upstream_bus_master dut (.clk_i, .resetn_i, .ce_i, .cmd_valid_i, .cmd_ready_o, .cmd_code_i,
    .cmd_addr_i, .cmd_be_i, .cmd_len_i, .cmd_lock_i, .cmd_cfg_sel_i, .wr_valid_i, .wr_ready_o,
    .wr_data_i, .rd_valid_o, .rd_ready_i, .rd_data_o, .done_o, .status_o, .req_n_o, .gnt_n_i,
    .ad_i(ad_b), .ad_o, .ad_oe_n_o, .upstream_cmd_byte_en_i(cbe_b), .upstream_cmd_byte_en_o,
    .cbe_oe_n_o, .upstream_parity_i(par_b), .upstream_parity_o, .par_oe_n_o,
    .frame_n_i(frame_b), .frame_n_o, .frame_oe_n_o, .upstream_initiator_ready_n_o, .irdy_oe_n_o,
    .upstream_target_ready_n_i(t_trdy), .upstream_claim_n_i(t_claim), .stop_n_i(t_stop),
    .lock_n_o, .lock_oe_n_o, .upstream_config_select_o, .par_err_o);
  bus_target far (.clk_i, .mode_i(mode), .frame_n_i(frame_b), .irdy_n_i(irdy_b), .ad_i(ad_b),
    .cbe_i(cbe_b), .trdy_n_o(t_trdy), .claim_n_o(t_claim), .stop_n_o(t_stop),
    .ad_drv_o(t_ad_drv), .ad_o(t_ad), .par_drv_o(t_par_drv), .par_o(t_par));
  always #5 clk_i = ~clk_i;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic logic [31:0] pop(ref logic [31:0] q[$]);
    return (q.size() > 0) ? q.pop_front() : 32'hX;
  endfunction : pop

  task automatic end_sim;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_sim

  always @(posedge clk_i)
  begin
    #1;
    // the read path has no back-pressure toward the bus, so the consumer never stalls
    rd_ready_i = 1'b1;
    gnt_n_i = req_n_o & 1'($random(seed));
  end

  always @(posedge clk_i)
  begin
    if (resetn_i)
    begin
      if (fr_q && !frame_b)
      begin
        chk(ad_b, cmd_addr_i);
        chk(32'(cbe_b), 32'(cmd_code_i));
        chk(32'(upstream_config_select_o), 32'(cmd_cfg_sel_i));
      end
      if (!irdy_b && !t_trdy)
      begin
        chk(32'(cbe_b), 32'(cmd_be_i));
        if (cmd_code_i[0])
          chk(ad_b, pop(wr_q));
      end
      if (par_oe_n_o === 1'b0)
        chk(32'(upstream_parity_o), 32'(^{ad_q, cbe_q}));
      if (rd_valid_o === 1'b1 && rd_ready_i)
        chk(rd_data_o, pop(rd_q));
      if (done_o === 1'b1)
      begin
        chk(32'(status_o), pop(st_q));
        chk(32'(wr_q.size()), 32'h0);
        dones++;
      end
      if (par_err_o !== 1'b0)
        chk(32'(par_err_o), 32'h0);
      if (adr_q && cmd_lock_i)
        chk(32'(lock_n_o), 32'h0);
      if (req_q && req_n_o === 1'b0)
        chk(32'(hi >= `REQ_IDLE_CYCLES), 32'h1);
    end
    hi = req_n_o ? hi + 1 : 0;
    adr_q = fr_q && !frame_b;
    {fr_q, req_q, ad_q, cbe_q, ad_h, cbe_h, par_h} = {frame_b, req_n_o, ad_b, cbe_b, ~ad_b,
      ~cbe_b, ~par_b};
  end

  task automatic run(input int i);
    int n, d0;
    @(posedge clk_i);
    #1;
    cmd_code_i = codes[i % 4];
    cmd_cfg_sel_i = cmd_code_i[3];
    cmd_len_i = 4'($random(seed)) & 4'h7;
    cmd_be_i = 4'($random(seed));
    cmd_lock_i = 1'($random(seed));
    cmd_addr_i = {30'($random(seed)), 2'h0};
    mode = cmd_code_i[0] ? 2'($random(seed)) & 2'h1 : (i < 8 ? 2'(i / 2) : 2'($random(seed)));
    st_q.push_back(mode == 2'h2 ? 32'h1 : mode == 2'h3 ? 32'h2 : 32'h0);
    for (int k = 0; k <= cmd_len_i && mode < 2 && !cmd_code_i[0]; k++)
      rd_q.push_back(cmd_addr_i + k);
    d0 = dones;
    cmd_valid_i = 1'b1;
    n = 0;
    @(posedge clk_i);
    while (cmd_ready_o !== 1'b1 && n++ < 100)
      @(posedge clk_i);
    #1;
    cmd_valid_i = 1'b0;
    for (int k = 0; k <= cmd_len_i && cmd_code_i[0]; k++)
    begin
      wr_data_i = $random(seed);
      wr_valid_i = 1'b1;
      wr_q.push_back(wr_data_i);
      n = 0;
      @(posedge clk_i);
      while (wr_ready_o !== 1'b1 && n++ < 100)
        @(posedge clk_i);
      #1;
    end
    wr_valid_i = 1'b0;
    n = 0;
    while (dones == d0 && n++ < 200)
      @(posedge clk_i);
    chk(32'(dones != d0), 32'h1);
    $display("test %0d mode %0d done", i, mode);
  endtask : run

  initial
  begin
    #200000;
    errors++;
    end_sim;
  end

  initial
  begin
    repeat (4) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    chk(32'({ad_oe_n_o, cbe_oe_n_o, par_oe_n_o, frame_oe_n_o, irdy_oe_n_o, req_n_o}),
      32'h3F);
    for (int i = 0; i < 16; i++)
      run(i);
    repeat (20) @(posedge clk_i);
    chk(32'(rd_q.size()), 32'h0);
    end_sim;
  end
endmodule : tb_top
